// ===== inc/cfr_pkg.sv
// Package for the full-frame CCD readout timing generator.
// Assumes a single 25 MHz system clock and an external ADC on the video out.
package cfr_pkg;

  // ==========================================================================
  // Clock and timing constants.
  localparam int CLK_MHZ     = 25;
  localparam int T_VPULSE_NS = 5000; // Vertical segment length; each pulse spans two.
  localparam int T_VMIN_NS   = 4000; // Least vertical pulse width.
  localparam int T_HSETUP_NS = 1000; // Horizontal setup after the transfer.
  // Least times round up to whole cycles.
  localparam int V_CYC  = (T_VPULSE_NS * CLK_MHZ + 999) / 1000;
  localparam int VMIN_CYC = (T_VMIN_NS * CLK_MHZ + 999) / 1000;
  localparam int HS_CYC = (T_HSETUP_NS * CLK_MHZ + 999) / 1000;
  localparam int PIX_PHASES = 4;     // Clocks per pixel, 160 ns.
  localparam int INTEG_DEF  = 250000; // Default integration, 10 ms.

  // ==========================================================================
  // Line layout, pixel indices from the first pixel of a line.
  localparam int PIX_PER_LINE = 2267;
  localparam int TEST_A_IDX   = 8;
  localparam int DREF_FIRST   = 12;
  localparam int ACT_FIRST    = 46;
  localparam int ACT_LAST     = 2229;
  localparam int DTAIL_LAST   = 2263;
  localparam int TEST_B_IDX   = 2264;

  // ==========================================================================
  // Frame layout, line indices.
  localparam int LINES_PER_FRAME = 1510;
  localparam int DARK_HEAD     = 34;
  localparam int DARK_TAIL     = 4;
  localparam int DARK_GUARD    = 2; // Dark lines next to the active area.
  localparam int ACT_LINE_LAST = LINES_PER_FRAME - DARK_TAIL - 1;

  // ==========================================================================
  // Types.
  typedef enum logic [2:0] {
    ST_IDLE, ST_INTEG, ST_VXFER, ST_HSETUP, ST_HREAD
  } cfr_state_e;

  // Phase clock levels driven to the sensor.
  typedef struct packed {
    logic vertical_phase_one;
    logic vertical_phase_two;
    logic horizontal_phase_one;
    logic horizontal_phase_two;
    logic reset_gate;
  } cfr_pins_s;

  // Region flags that travel with each pixel.
  typedef struct packed {
    logic inactive;
    logic test;
    logic dark_ref;    // Dark pixel usable as true dark level.
    logic dark_suspect; // Dark pixel near the active area.
    logic active;
  } cfr_region_s;

endpackage

// ===== core/cfr_sequencer.sv
// Readout timing generator for a two-phase full-frame CCD sensor.
// Assumes the phase clock outputs reach the sensor through level shifters
// and that adc_data is an ADC sample of the video output, asynchronous.
`timescale 1ns/1ps

// Functional notes
// - Vertical phases stay low, unchanging, for the whole integration time.
// - Line enters horizontal register on vertical one falling, horizontal two high.
// - Horizontal phases toggle alternately and always complementary during readout.
// - Reset gate pulse in phase 0 follows each signal level sample.
// - Reset gate toggles once per pixel, continuously, never gated off.
// - Each vertical pulse lasts two 5 us segments, 10 us, at least 4 us.
module cfr_sequencer #(
  parameter int INTEG_CYCLES = cfr_pkg::INTEG_DEF,
  parameter int ADC_W        = 16
) (
  // Clock and reset.
  input  wire logic               sys_clk,
  input  wire logic               rstn,
  // Frame control from local logic.
  input  wire logic               start_frame,
  output logic                    busy,
  output logic                    frame_done,
  // Sensor phase clocks.
  output cfr_pkg::cfr_pins_s      pins,
  // Video samples from the external ADC.
  input  wire logic [ADC_W-1:0]   adc_data,
  // Pixel stream out.
  output logic                    pix_valid,
  output logic [ADC_W-1:0]        pix_value,
  output cfr_pkg::cfr_region_s    pix_region,
  output logic [11:0]             pix_col,
  output logic [10:0]             pix_line
);

  // ==========================================================================
  // Region decoding.

  // Classifies one pixel by its column and line position.
  function automatic cfr_pkg::cfr_region_s region_of(
    input logic [11:0] col,
    input logic [10:0] line
  );
    cfr_pkg::cfr_region_s r;
    logic dark_line;
    logic guard_line;
    r = '0;
    dark_line  = (line < 11'(cfr_pkg::DARK_HEAD)) ||
                 (line > 11'(cfr_pkg::ACT_LINE_LAST));
    guard_line = (line >= 11'(cfr_pkg::DARK_HEAD - cfr_pkg::DARK_GUARD) &&
                  line <  11'(cfr_pkg::DARK_HEAD)) ||
                 (line >  11'(cfr_pkg::ACT_LINE_LAST) &&
                  line <= 11'(cfr_pkg::ACT_LINE_LAST + cfr_pkg::DARK_GUARD));
    if (col == 12'(cfr_pkg::TEST_A_IDX) ||
        col == 12'(cfr_pkg::TEST_B_IDX)) begin
      r.test = 1'b1;
    end else if (col < 12'(cfr_pkg::DREF_FIRST) ||
                 col > 12'(cfr_pkg::DTAIL_LAST)) begin
      r.inactive = 1'b1;
    end else if (col >= 12'(cfr_pkg::ACT_FIRST) &&
                 col <= 12'(cfr_pkg::ACT_LAST) && !dark_line) begin
      r.active = 1'b1;
    end else if (guard_line ||
                 col == 12'(cfr_pkg::ACT_LAST + 1)) begin
      r.dark_suspect = 1'b1;
    end else begin
      r.dark_ref = 1'b1;
    end
    return r;
  endfunction

  // ==========================================================================
  // ADC input synchroniser.

  logic [ADC_W-1:0] adc_s1_q;
  logic [ADC_W-1:0] adc_s2_q;

  // Two flops before any logic looks at the ADC word.
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      adc_s1_q <= '0;
      adc_s2_q <= '0;
    end else begin
      adc_s1_q <= adc_data;
      adc_s2_q <= adc_s1_q;
    end
  end

  // ==========================================================================
  // Sequencer state.

  cfr_pkg::cfr_state_e   state_q, state_d;
  logic [1:0]            seg_q, seg_d;
  logic [31:0]           tmr_q, tmr_d;
  logic [1:0]            phase_q, phase_d;
  logic [11:0]           col_q, col_d;
  logic [10:0]           line_q, line_d;
  logic                  done_q, done_d;
  cfr_pkg::cfr_pins_s    pins_q, pins_d;
  logic [ADC_W-1:0]      rst_lvl_q, rst_lvl_d;
  logic                  valid_q, valid_d;
  logic [ADC_W-1:0]      value_q, value_d;
  cfr_pkg::cfr_region_s  region_q, region_d;
  logic [11:0]           ocol_q, ocol_d;
  logic [10:0]           oline_q, oline_d;
  logic                  pend_q, pend_d;
  logic [11:0]           pcol_q, pcol_d;
  logic [10:0]           pline_q, pline_d;

  // Next-state logic: integration, line transfer, setup and pixel readout.
  always_comb begin
    state_d   = state_q;
    seg_d     = seg_q;
    tmr_d     = tmr_q;
    col_d     = col_q;
    line_d    = line_q;
    done_d    = 1'b0;
    rst_lvl_d = rst_lvl_q;
    valid_d   = 1'b0;
    value_d   = value_q;
    region_d  = region_q;
    ocol_d    = ocol_q;
    oline_d   = oline_q;
    pend_d    = pend_q;
    pcol_d    = pcol_q;
    pline_d   = pline_q;
    phase_d   = phase_q + 2'd1; // Free-running pixel phase.
    case (state_q)
      cfr_pkg::ST_IDLE: begin
        if (start_frame && !pend_q) begin
          state_d = cfr_pkg::ST_INTEG;
          tmr_d   = '0;
          line_d  = '0;
        end
      end
      cfr_pkg::ST_INTEG: begin
        tmr_d = tmr_q + 32'd1;
        if (tmr_q >= 32'(INTEG_CYCLES - 1)) begin
          state_d = cfr_pkg::ST_VXFER;
          seg_d   = 2'd0;
          tmr_d   = '0;
        end
      end
      cfr_pkg::ST_VXFER: begin
        tmr_d = tmr_q + 32'd1;
        if (tmr_q == 32'(cfr_pkg::V_CYC - 1)) begin
          tmr_d = '0;
          if (seg_q == 2'd2) begin
            state_d = cfr_pkg::ST_HSETUP;
          end else begin
            seg_d = seg_q + 2'd1;
          end
        end
      end
      cfr_pkg::ST_HSETUP: begin
        if (tmr_q < 32'(cfr_pkg::HS_CYC - 1)) begin
          tmr_d = tmr_q + 32'd1;
        end else if (phase_q == 2'd3) begin
          state_d = cfr_pkg::ST_HREAD;
          col_d   = '0;
        end
      end
      cfr_pkg::ST_HREAD: begin
        // Reset level of this pixel: the pin register and the two sync
        // flops delay the video by two cycles, so the ADC word seen at
        // phase 3 shows the pins of phase 1, just after the reset pulse.
        if (phase_q == 2'd3) begin
          rst_lvl_d = adc_s2_q;
          pend_d    = 1'b1;
          pcol_d    = col_q;
          pline_d   = line_q;
          if (col_q == 12'(cfr_pkg::PIX_PER_LINE - 1)) begin
            if (line_q == 11'(cfr_pkg::LINES_PER_FRAME - 1)) begin
              state_d = cfr_pkg::ST_IDLE;
            end else begin
              line_d  = line_q + 11'd1;
              state_d = cfr_pkg::ST_VXFER;
              seg_d   = 2'd0;
              tmr_d   = '0;
            end
          end else begin
            col_d = col_q + 12'd1;
          end
        end
      end
      default: begin
        state_d = cfr_pkg::ST_IDLE;
      end
    endcase

    // Signal level two cycles later: the ADC word seen at phase 1 shows the
    // pins of phase 3, after horizontal one fell and before the next reset
    // pulse. This also runs after the last pixel of a line or frame.
    if (pend_q && (phase_q == 2'd1)) begin
      pend_d   = 1'b0;
      valid_d  = 1'b1;
      value_d  = rst_lvl_q - adc_s2_q;
      region_d = region_of(pcol_q, pline_q);
      ocol_d   = pcol_q;
      oline_d  = pline_q;
      done_d   = (pcol_q == 12'(cfr_pkg::PIX_PER_LINE - 1)) &&
                 (pline_q == 11'(cfr_pkg::LINES_PER_FRAME - 1));
    end

    // Vertical phases low outside transfers; one falls in segment 2.
    pins_d.vertical_phase_one = (state_d == cfr_pkg::ST_VXFER) &&
                                (seg_d != 2'd2);
    pins_d.vertical_phase_two = (state_d == cfr_pkg::ST_VXFER) &&
                                (seg_d != 2'd0);
    // Horizontal one high in phases 0 and 1, falls entering phase 2.
    pins_d.horizontal_phase_one = (state_d == cfr_pkg::ST_HREAD) &&
                                  !phase_d[1];
    pins_d.horizontal_phase_two = !pins_d.horizontal_phase_one;
    // One reset pulse per pixel, after the previous signal sample.
    pins_d.reset_gate = (phase_d == 2'd0);
  end

  // Registers of the sequencer.
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      state_q   <= cfr_pkg::ST_IDLE;
      seg_q     <= '0;
      tmr_q     <= '0;
      phase_q   <= '0;
      col_q     <= '0;
      line_q    <= '0;
      done_q    <= 1'b0;
      pins_q    <= 5'h02; // Only horizontal two high.
      rst_lvl_q <= '0;
      valid_q   <= 1'b0;
      value_q   <= '0;
      region_q  <= '0;
      ocol_q    <= '0;
      oline_q   <= '0;
      pend_q    <= 1'b0;
      pcol_q    <= '0;
      pline_q   <= '0;
    end else begin
      state_q   <= state_d;
      seg_q     <= seg_d;
      tmr_q     <= tmr_d;
      phase_q   <= phase_d;
      col_q     <= col_d;
      line_q    <= line_d;
      done_q    <= done_d;
      pins_q    <= pins_d;
      rst_lvl_q <= rst_lvl_d;
      valid_q   <= valid_d;
      value_q   <= value_d;
      region_q  <= region_d;
      ocol_q    <= ocol_d;
      oline_q   <= oline_d;
      pend_q    <= pend_d;
      pcol_q    <= pcol_d;
      pline_q   <= pline_d;
    end
  end

  // Output assignments, all from registers.
  // Busy also covers the last pixel still on its way out.
  assign busy       = (state_q != cfr_pkg::ST_IDLE) || pend_q;
  assign frame_done = done_q;
  assign pins       = pins_q;
  assign pix_valid  = valid_q;
  assign pix_value  = value_q;
  assign pix_region = region_q;
  assign pix_col    = ocol_q;
  assign pix_line   = oline_q;

endmodule

// ===== dv/cfr_seq_asserts.sv
// Checker for the sequencer phase pins and pixel stream.
// Assumes it is bound to cfr_sequencer and integration lasts 8+ cycles.
`timescale 1ns/1ps
module cfr_seq_asserts (
  // Clock and reset.
  input wire logic                 sys_clk,
  input wire logic                 rstn,
  // Watched outputs.
  input wire logic                 busy,
  input wire cfr_pkg::cfr_pins_s   pins,
  input wire logic                 pix_valid,
  input wire cfr_pkg::cfr_region_s pix_region
);
  // ==========================================================================
  // Helper: length of the present vertical one pulse.
  logic [9:0] vlen_q;
  logic [9:0] vlen_d;
  always_comb vlen_d = pins.vertical_phase_one ? vlen_q + 10'h001 : 10'h000;
  // Registers the pulse length.
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) vlen_q <= 10'h000;
    else vlen_q <= vlen_d;
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  // ==========================================================================
  // Assertions.
  a_idle_v_quiet: assert property (!busy |-> !pins.vertical_phase_one
    && !pins.vertical_phase_two) else $error("vertical moved in idle");
  a_integ_v_quiet: assert property ($rose(busy) |->
    (!pins.vertical_phase_one && !pins.vertical_phase_two)[*8])
    else $error("vertical moved in integration");
  a_xfer_h2_high: assert property ($fell(pins.vertical_phase_one)
    |-> pins.horizontal_phase_two) else $error("h2 low at v1 fall");
  a_h_compl: assert property (pins.horizontal_phase_one
    != pins.horizontal_phase_two) else $error("h phases not complementary");
  a_vpulse_min: assert property ($fell(pins.vertical_phase_one)
    |-> $past(vlen_q) >= cfr_pkg::VMIN_CYC) else $error("v pulse short");
  a_rg_period: assert property ($rose(pins.reset_gate)
    |-> ##4 $rose(pins.reset_gate)) else $error("reset gate not periodic");
  a_rg_after_h1: assert property ($fell(pins.horizontal_phase_one) |->
    !pins.reset_gate ##1 !pins.reset_gate)
    else $error("reset gate misplaced");
  a_pix_spacing: assert property (pix_valid |=> !pix_valid[*3])
    else $error("pixel pulses too close");
  a_region_onehot: assert property (pix_valid |-> $onehot(pix_region))
    else $error("region not one-hot");
endmodule

bind cfr_sequencer cfr_seq_asserts u_chk (.sys_clk(sys_clk), .rstn(rstn),
  .busy(busy), .pins(pins), .pix_valid(pix_valid), .pix_region(pix_region));

// ===== dv/cfr_ccd_model.sv
// Behavioural sensor: phase pins in, video level out to the ADC input.
// Assumes pins arrive as levels with no analog delay.
`timescale 1ns/1ps
module cfr_ccd_model #(
  parameter logic [15:0] RST_LVL = 16'hC000
) (
  // Bench reset, clears the line count.
  input  wire logic               rstn,
  // Phase clocks in, video out.
  input  wire cfr_pkg::cfr_pins_s pins,
  output logic [15:0]             video
);
  // ==========================================================================
  int          col = 0;
  int          line = -1;
  logic [15:0] chg = 16'h0000;
  // The line count restarts with each reset.
  always @(negedge rstn) line = -1;
  // A line lands on vertical one falling while horizontal two is high.
  always @(negedge pins.vertical_phase_one) begin
    if (pins.horizontal_phase_two && rstn) begin
      line++;
      col = -1;
    end
  end
  // Each horizontal one fall moves one packet to the sense node.
  always @(negedge pins.horizontal_phase_one) begin
    if (rstn) begin
      col++;
      chg = 16'(col + line * 4096);
    end
  end
  // The reset gate empties the sense node.
  always @(posedge pins.reset_gate) chg = 16'h0000;
  // More charge gives a lower level.
  assign video = RST_LVL - chg;
endmodule

// ===== dv/cfr_sequencer_bench.sv
// Bench for the sequencer driving the behavioural sensor model.
// Assumes the model answers at once on adc_data.
`timescale 1ns/1ps
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin \
  num_errors++; $display("Error %s exp %0h got %0h", n, e, g); end end
module cfr_sequencer_bench;
  // ==========================================================================
  localparam int INTEG = 10;
  logic                 sys_clk, rstn, start_frame, busy, frame_done, pix_valid;
  cfr_pkg::cfr_pins_s   pins;
  cfr_pkg::cfr_region_s pix_region;
  logic [15:0]          adc_data, pix_value;
  logic [11:0]          pix_col;
  logic [10:0]          pix_line;
  int                   num_errors, samples_checked;
  int                   cycles = 0;
  cfr_sequencer #(.INTEG_CYCLES(INTEG), .ADC_W(16)) dut_u (.sys_clk(sys_clk),
    .rstn(rstn), .start_frame(start_frame), .busy(busy),
    .frame_done(frame_done), .pins(pins), .adc_data(adc_data),
    .pix_valid(pix_valid), .pix_value(pix_value), .pix_region(pix_region),
    .pix_col(pix_col), .pix_line(pix_line));
  cfr_ccd_model ccd_u (.rstn(rstn), .pins(pins), .video(adc_data));
  // Clock and hang guard.
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 40000) begin
      num_errors++;
      final_report();
    end
  end
  task automatic final_report();
    if (num_errors == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // Region the bench expects at a line and column.
  function automatic cfr_pkg::cfr_region_s exp_region(int l, int c);
    if (c == 8 || c == 2264) return 5'b01000;
    if (c < 12 || c > 2264) return 5'b10000;
    if (l >= 34 && l <= 1505 && c >= 46 && c <= 2229) return 5'b00001;
    if (c == 2230 || l == 32 || l == 33 || l == 1506 || l == 1507)
      return 5'b00010;
    return 5'b00100;
  endfunction
  // ==========================================================================
  task automatic reset_dut(int n);
    @(posedge sys_clk) rstn <= 1'b0;
    repeat (n) @(posedge sys_clk);
    #1 `CHK("pins", 5'b00010, pins)
    `CHK("busy", 1'b0, busy)
    @(posedge sys_clk) rstn <= 1'b1;
  endtask
  task automatic test_integ();
    @(posedge sys_clk) start_frame <= 1'b1;
    @(posedge sys_clk) start_frame <= 1'b0;
    @(posedge sys_clk) #1 `CHK("busy", 1'b1, busy)
    repeat (INTEG - 2) begin
      `CHK("v_quiet", 2'b00, pins[4:3])
      @(posedge sys_clk) #1;
    end
  endtask
  task automatic test_xfer();
    int n;
    n = 0;
    while (!pins.vertical_phase_one && n < 100) begin
      @(posedge sys_clk) #1;
      n++;
    end
    n = 0;
    while (pins.vertical_phase_one && n < 400) begin
      `CHK("h2_hold", 1'b1, pins.horizontal_phase_two)
      @(posedge sys_clk) #1;
      n++;
    end
    `CHK("v1_width", 2 * cfr_pkg::V_CYC, n)
  endtask
  task automatic test_lines(int nl);
    int gap;
    for (int l = 0; l < nl; l++) begin
      for (int c = 0; c < 2267; c++) begin
        gap = 0;
        do begin
          @(posedge sys_clk) #1;
          gap++;
        end while (pix_valid !== 1'b1 && gap < 1000);
        `CHK("pix_valid", 1'b1, pix_valid)
        `CHK("frame_done", 1'b0, frame_done)
        if (c > 0) `CHK("pix_gap", 4, gap)
        `CHK("col", 12'(c), pix_col)
        `CHK("line", 11'(l), pix_line)
        `CHK("value", 16'(c + l * 4096), pix_value)
        `CHK("region", exp_region(l, c), pix_region)
      end
    end
  endtask
  initial begin
    rstn = 1'b0;
    start_frame = 1'b0;
    num_errors = 0;
    samples_checked = 0;
    reset_dut(20);
    test_integ();
    test_xfer();
    test_lines(2);
    reset_dut(3);
    test_integ();
    test_xfer();
    test_lines(1);
    final_report();
  end
endmodule
